// ===== rtl/sample_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes a single clock and synchronous active-high reset.
 */
`timescale 1ns/10ps
module sample_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 16
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    // Pointer wrap relies on a power-of-two depth
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("DEPTH must be a power of two >= 2");
    end
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic push, pop;

    // Honest full and empty from pointer difference
    always_comb begin
        in_ready_o = (wp_r - rp_r) != (AW+1)'(DEPTH);
        out_valid_o = wp_r != rp_r;
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        wp_nxt = push ? wp_r + (AW+1)'(1) : wp_r;
        rp_nxt = pop ? rp_r + (AW+1)'(1) : rp_r;
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
    end

    // Storage has no reset; only written words are ever read
    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem_r[wp_r[AW-1:0]] <= in_data_i;
        end
    end
    assign out_data_o = mem_r[rp_r[AW-1:0]];
endmodule : sample_fifo

// ===== rtl/serial_audio_in.sv
/*
 * Serial audio input stage: samples bit clock, channel clock and data
 * on the core clock, deframes LJ/I2S/RJ words and queues them.
 * Assumes bit clock period at least 80 ns against an 8 ns core clock,
 * and format/width held steady while the link runs.
 */
`include "sin_consts.svh"
`timescale 1ns/10ps
module serial_audio_in
    import sin_pkg::*;
#(
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic bclk_i,
    input wire logic lrclk_i,
    input wire logic sdata_i,
    input wire logic [1:0] fmt_i,
    input wire logic [1:0] width_i,
    output logic smp_valid_o,
    input wire logic smp_ready_i,
    output logic [`SMP_W-1:0] smp_data_o,
    output logic smp_right_o,
    output logic overrun_o
);
    // Queue needs at least two words to tell full from empty
    if (FIFO_DEPTH < 2) begin : g_bad_depth
        $error("FIFO_DEPTH too small");
    end

    // Two-stage synchronisers; stage one feeds only stage two
    logic [2:0] s1_r, s1_nxt, s2_r, s2_nxt;
    logic bclk_d_r, bclk_d_nxt;
    always_comb begin
        s1_nxt = {bclk_i, lrclk_i, sdata_i};
        s2_nxt = s1_r;
        bclk_d_nxt = s2_r[2];
    end
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            s1_r <= '0;
            s2_r <= '0;
            bclk_d_r <= 1'b0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            bclk_d_r <= bclk_d_nxt;
        end
    end
    logic bclk_rise, lr_s, sd_s;
    assign bclk_rise = s2_r[2] && !bclk_d_r;
    assign lr_s = s2_r[1];
    assign sd_s = s2_r[0];

    // Word width in bits from code
    function automatic logic [5:0] width_bits(input logic [1:0] w);
        case (w)
            `WID_16: width_bits = 6'd16;
            `WID_18: width_bits = 6'd18;
            `WID_20: width_bits = 6'd20;
            default: width_bits = 6'd24;
        endcase
    endfunction : width_bits

    fmt_t fmt;
    assign fmt = fmt_t'(fmt_i);
    logic [5:0] wbits;
    assign wbits = width_bits(width_i);

    // Deframer state
    rx_state_t st_r, st_nxt;
    logic lr_d_r, lr_d_nxt;
    logic lr_seen_r, lr_seen_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic [5:0] rj_r, rj_nxt;
    logic [`SMP_W-1:0] sh_r, sh_nxt;
    logic ch_r, ch_nxt;
    logic push_v;
    logic [`SMP_W:0] push_d;
    logic fifo_rdy;
    logic ovr_r, ovr_nxt;
    logic lr_edge;
    logic is_right;

    // First rise after reset only learns the level, so a high pin is no false edge
    assign lr_edge = bclk_rise && lr_seen_r && (lr_s != lr_d_r);
    // I2S left is low; LJ and RJ left is high
    assign is_right = (fmt == FMT_I2S_E) ? lr_s : !lr_s;

    // Next-state of the deframer; every decision but the word-complete check sits on a bit clock rise
    always_comb begin
        st_nxt = st_r;
        lr_d_nxt = lr_d_r;
        lr_seen_nxt = lr_seen_r;
        cnt_nxt = cnt_r;
        rj_nxt = rj_r;
        sh_nxt = sh_r;
        ch_nxt = ch_r;
        push_v = 1'b0;
        push_d = {ch_r, sh_r};
        ovr_nxt = ovr_r;
        if (bclk_rise) begin
            lr_d_nxt = lr_s;
            lr_seen_nxt = 1'b1;
            rj_nxt = rj_r + 6'd1;
            if (lr_edge) begin
                ch_nxt = is_right;
                cnt_nxt = 6'd0;
                sh_nxt = '0;
                rj_nxt = 6'd1;
                if (st_r == ST_SHIFT && fmt != FMT_RJ_E) begin
                    st_nxt = ST_SHIFT;
                end
                case (fmt)
                    FMT_I2S_E: st_nxt = ST_SKIP;
                    FMT_LJ_E: begin
                        st_nxt = ST_SHIFT;
                        sh_nxt = {{(`SMP_W-1){1'b0}}, sd_s};
                        cnt_nxt = 6'd1;
                    end
                    FMT_RJ_E: begin
                        st_nxt = ST_WAIT;
                        // Previous half ends here: LSB right-justified to this edge
                        if (st_r == ST_WAIT && rj_r == 6'd32) begin
                            push_v = 1'b1;
                            push_d = {ch_r, sh_r};
                        end
                    end
                    default: st_nxt = ST_IDLE;
                endcase
            end else begin
                case (st_r)
                    ST_SKIP: begin
                        st_nxt = ST_SHIFT;
                        sh_nxt = {{(`SMP_W-1){1'b0}}, sd_s};
                        cnt_nxt = 6'd1;
                    end
                    ST_SHIFT: begin
                        sh_nxt = {sh_r[`SMP_W-2:0], sd_s};
                        cnt_nxt = cnt_r + 6'd1;
                    end
                    ST_WAIT: begin
                        // Keep the last wbits bits shifted before the next edge
                        sh_nxt = {sh_r[`SMP_W-2:0], sd_s};
                    end
                    ST_IDLE: st_nxt = ST_IDLE;
                    default: st_nxt = ST_IDLE;
                endcase
            end
        end
        // LJ/I2S word complete: stop shifting, surplus bit clocks ignored
        if (st_r == ST_SHIFT && cnt_r == wbits) begin
            st_nxt = lr_edge ? st_nxt : ST_IDLE;
            push_v = 1'b1;
            push_d = {ch_r, sh_r};
            if (!lr_edge) begin
                cnt_nxt = 6'd0;
            end
        end
        if (push_v) begin
            if (st_r == ST_WAIT) begin
                push_d = {ch_r, mask_rj(sh_r, wbits)};
            end
            if (!fifo_rdy) begin
                ovr_nxt = 1'b1; // Sample lost, source cannot be stalled
            end
        end
    end

    // Right-justified words keep only the low wbits bits
    function automatic logic [`SMP_W-1:0] mask_rj(input logic [`SMP_W-1:0] v,
                                                 input logic [5:0] n);
        logic [`SMP_W-1:0] m;
        m = ~({`SMP_W{1'b1}} << n);
        mask_rj = v & m;
    endfunction : mask_rj

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            st_r <= ST_IDLE;
            lr_d_r <= 1'b0;
            lr_seen_r <= 1'b0;
            cnt_r <= 6'd0;
            rj_r <= 6'd0;
            sh_r <= '0;
            ch_r <= 1'b0;
            ovr_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            lr_d_r <= lr_d_nxt;
            lr_seen_r <= lr_seen_nxt;
            cnt_r <= cnt_nxt;
            rj_r <= rj_nxt;
            sh_r <= sh_nxt;
            ch_r <= ch_nxt;
            ovr_r <= ovr_nxt;
        end
    end
    assign overrun_o = ovr_r;

    // Queue absorbs encoder stalls; its ready flags overrun
    sample_fifo #(
        .WIDTH(`SMP_W + 1),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .in_valid_i(push_v),
        .in_ready_o(fifo_rdy),
        .in_data_i(push_d),
        .out_valid_o(smp_valid_o),
        .out_ready_i(smp_ready_i),
        .out_data_o({smp_right_o, smp_data_o})
    );

    // Assertions
    sequence s_rise;
        bclk_rise;
    endsequence
    AST_CAPTURE_ON_RISE: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (st_r == ST_SHIFT && !bclk_rise && !(cnt_r == wbits)) |=> $stable(sh_r))
        else $error("shift register moved without bit clock rise");
    AST_I2S_DELAY: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (lr_edge && fmt == FMT_I2S_E) |=> st_r == ST_SKIP)
        else $error("I2S did not skip one bit clock");
    AST_LJ_NODELAY: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (lr_edge && fmt == FMT_LJ_E) |=> (st_r == ST_SHIFT && cnt_r == 6'd1))
        else $error("LJ did not take MSB at channel edge");
    AST_RJ_WAIT: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (lr_edge && fmt == FMT_RJ_E) |=> st_r == ST_WAIT)
        else $error("RJ did not wait for right-justified word");
    AST_I2S_CHANNEL: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (lr_edge && fmt == FMT_I2S_E && !lr_s) |=> !ch_r)
        else $error("I2S low channel clock not left");
    AST_LJ_CHANNEL: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (lr_edge && fmt == FMT_LJ_E && lr_s) |=> !ch_r)
        else $error("LJ high channel clock not left");
    AST_RJ_CHANNEL: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (lr_edge && fmt == FMT_RJ_E && lr_s) |=> !ch_r)
        else $error("RJ high channel clock not left");
    AST_WIDTH_STOP: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (st_r == ST_SHIFT && cnt_r == wbits && !lr_edge) |=> st_r == ST_IDLE)
        else $error("shifting went past word width");
    AST_WIDTH_BOUND: assert property (@(posedge core_clk_i) disable iff (srst_i)
        s_rise |-> cnt_r <= 6'd24)
        else $error("bit count beyond largest width");
endmodule : serial_audio_in

// ===== rtl/sin_consts.svh
/*
 * Constants of the serial audio input stage: format codes, word widths,
 * timing figures. Assumes inclusion by bare name from rtl files.
 */
`ifndef SIN_CONSTS_SVH
`define SIN_CONSTS_SVH
`define FMT_LJ 2'h0
`define FMT_I2S 2'h1
`define FMT_RJ 2'h2
`define WID_16 2'h0
`define WID_18 2'h1
`define WID_20 2'h2
`define WID_24 2'h3
`define SMP_W 24
`define FIFO_DEPTH 16
`define CORE_PERIOD_NS 8
`define SCLK_MIN_PERIOD_NS 80
`define SCLK_MIN_CYC ((`SCLK_MIN_PERIOD_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)
`endif

// ===== rtl/sin_pkg.sv
/*
 * Types of the serial audio input stage. Assumes sin_consts.svh beside it.
 */
package sin_pkg;
    typedef enum logic [1:0] {FMT_LJ_E, FMT_I2S_E, FMT_RJ_E, FMT_RSV_E} fmt_t;
    typedef enum logic [1:0] {WID16_E, WID18_E, WID20_E, WID24_E} wid_t;
    typedef enum {ST_WAIT, ST_SKIP, ST_SHIFT, ST_IDLE} rx_state_t;
endpackage : sin_pkg

// ===== test/audio_src_model.sv
/*
 * Upstream serial audio source: makes bit clock, channel clock and data
 * with a 160 ns bit period. Assumes the bench calls half() in sequence.
 */
`timescale 1ns/10ps
module audio_src_model (
    output logic bclk_o,
    output logic lrclk_o,
    output logic sdata_o
);
    // Bit clock rests low outside frames
    initial begin
        bclk_o = 1'b0;
        lrclk_o = 1'b1;
        sdata_o = 1'b0;
    end

    // One bit period; data moves on the fall so it is settled at the rise
    task automatic bit_out(input logic lr, input logic d);
        lrclk_o = lr;
        sdata_o = d;
        #80;
        bclk_o = 1'b1;
        #80;
        bclk_o = 1'b0;
    endtask : bit_out

    // One channel half of nb bit clocks; slots outside the word toggle
    task automatic half(input logic [1:0] fmt, input int w, input logic right,
                        input logic [23:0] smp, input int nb);
        int first;
        logic lr;
        lr = (fmt == 2'h1) ? right : ~right;
        first = (fmt == 2'h0) ? 0 : (fmt == 2'h1) ? 1 : 32 - w;
        for (int s = 0; s < nb; s++) begin
            if (s >= first && s < first + w) begin
                bit_out(lr, smp[w - 1 - (s - first)]);
            end else begin
                bit_out(lr, s[0]);
            end
        end
        sdata_o = ~sdata_o; // Released line must not keep the last bit
    endtask : half
endmodule : audio_src_model

// ===== test/spdif_tx_serial_input_port_tb.sv
/*
 * Bench of the serial audio input stage: all formats and widths, idle
 * code, FIFO overrun and drain. Assumes audio_src_model drives the link.
 */
`include "sin_consts.svh"
`timescale 1ns/10ps
module spdif_tx_serial_input_port_tb import sin_pkg::*; ;
    logic core_clk_i, srst_i, rdy_en;
    logic smp_ready_i = 1'b0;
    logic [1:0] fmt_i, width_i;
    wire logic bclk, lrclk, sdata;
    logic smp_valid_o, smp_right_o, overrun_o;
    logic [`SMP_W-1:0] smp_data_o;
    logic [24:0] got_q[$];
    int fails, total_checks;
    int wtab[4] = '{16, 18, 20, 24};

    serial_audio_in #(.FIFO_DEPTH(4)) u_serial_audio_in (.core_clk_i(core_clk_i),
        .srst_i(srst_i), .bclk_i(bclk), .lrclk_i(lrclk), .sdata_i(sdata), .fmt_i(fmt_i),
        .width_i(width_i), .smp_valid_o(smp_valid_o), .smp_ready_i(smp_ready_i),
        .smp_data_o(smp_data_o), .smp_right_o(smp_right_o), .overrun_o(overrun_o));
    audio_src_model u_audio_src_model (.bclk_o(bclk), .lrclk_o(lrclk), .sdata_o(sdata));

    // Clock and time-zero values
    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end

    // Consumer stalls every other cycle to keep words waiting in the FIFO
    always @(posedge core_clk_i) begin
        if (smp_valid_o === 1'b1 && smp_ready_i === 1'b1) got_q.push_back({smp_right_o, smp_data_o});
        smp_ready_i <= rdy_en ? ~smp_ready_i : 1'b0;
    end

    task automatic check(input logic [24:0] seen, input logic [24:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    // Reset held two cycles; outputs must be quiet afterwards
    task automatic do_reset(input logic [1:0] f, input logic [1:0] wc);
        @(posedge core_clk_i);
        srst_i <= 1'b1;
        fmt_i <= f;
        width_i <= wc;
        repeat (2) @(posedge core_clk_i);
        srst_i <= 1'b0;
        @(posedge core_clk_i);
        #3;
        check({23'h0, smp_valid_o, overrun_o}, 25'h0);
        got_q.delete();
    endtask : do_reset

    // Bounded wait until the FIFO is empty
    task automatic drain();
        int n;
        n = 0;
        while (smp_valid_o !== 1'b0 && n < 500) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        if (n == 500) begin
            fails++;
            close_out();
        end
        repeat (2) @(posedge core_clk_i);
    endtask : drain

    // Lead-in half, frames, short tail; judge the last frames captured
    task automatic run_case(input logic [1:0] f, input logic [1:0] wc, input int nfr);
        int w, k;
        logic [23:0] l, r;
        w = wtab[wc];
        l = 24'hd2b4e7 & ((24'h1 << w) - 24'h1);
        r = 24'h2d4b18 & ((24'h1 << w) - 24'h1);
        do_reset(f, wc);
        u_audio_src_model.half(f, w, 1'b1, 24'h0, 32);
        repeat (nfr) begin
            u_audio_src_model.half(f, w, 1'b0, l, 32);
            u_audio_src_model.half(f, w, 1'b1, r, 32);
        end
        u_audio_src_model.half(f, w, 1'b0, 24'h0, 4);
        if (rdy_en && nfr > 0) begin
            drain();
            check(25'(got_q.size() >= 4), 25'h1);
            for (int i = 0; i < 4; i++) begin
                k = got_q.size() - 4 + i;
                check(got_q[k], i[0] ? {1'b1, r} : {1'b0, l});
            end
        end
    endtask : run_case

    task automatic t_format(input logic [1:0] f);
        for (int i = 0; i < 4; i++) run_case(f, 2'(i), 2);
        $display("format %0d done", f);
    endtask : t_format

    // Code 3 idles: a lead-in half and a short tail yield nothing
    task automatic t_idle();
        run_case(2'h3, 2'h3, 0);
        drain();
        check(25'(got_q.size()), 25'h0);
        $display("idle done");
    endtask : t_idle

    // Consumer held off: FIFO fills, later words drop and overrun sticks
    task automatic t_overrun();
        rdy_en = 1'b0;
        run_case(2'h1, 2'h3, 3);
        check({23'h0, smp_valid_o, overrun_o}, 25'h3);
        rdy_en = 1'b1;
        drain();
        check({overrun_o, 24'(got_q.size())}, {1'b1, 24'h4});
        $display("overrun done");
    endtask : t_overrun

    // Hang guard
    initial begin
        repeat (90000) @(posedge core_clk_i);
        fails++;
        close_out();
    end

    // Main sequence
    initial begin
        srst_i = 1'b1;
        fmt_i = 2'h1;
        width_i = 2'h0;
        rdy_en = 1'b1;
        fails = 0;
        total_checks = 0;
        t_format(2'h0);
        t_format(2'h1);
        t_format(2'h2);
        t_idle();
        t_overrun();
        close_out();
    end
endmodule : spdif_tx_serial_input_port_tb
